// [verilog/brk_idle_defines.svh]
`ifndef BRK_IDLE_DEFINES_SVH
`define BRK_IDLE_DEFINES_SVH

// frame length in bit times: start + data + stop
`define FRAME_BITS_SHORT 4'd10
`define FRAME_BITS_LONG 4'd11
// default baud divider: 50 MHz / 19200 baud, rounded down
`define BAUD_DIV_DEFAULT 16'd2604
`define LINE_MARK 1'b1
`define LINE_SPACE 1'b0

`endif

// [verilog/brk_idle_pkg.sv]
package brk_idle_pkg;
	typedef enum logic [1:0] {
		TX_OFF,
		TX_READY,
		TX_IDLE,
		TX_BREAK
	} txState_e;
endpackage

// [verilog/baud_tick_if.sv]
`timescale 1ns/1ps
interface baud_tick_if;
	logic restart;
	logic tick;
	modport src (input restart, output tick);
	modport dst (output restart, input tick);
endinterface

// [verilog/baud_tick_gen.sv]
`timescale 1ns/1ps
`include "brk_idle_defines.svh"
module baud_tick_gen #(
	parameter int DIV_W = 16
) (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic [DIV_W-1:0] baudDiv, // clocks per bit time
	baud_tick_if.src bt // restart in, tick out
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb
	begin
		tick_d = 1'b0;
		cnt_d = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
		if (bt.restart)
		begin
			cnt_d = '0;
		end
		else if (cnt_q + {{(DIV_W-1){1'b0}}, 1'b1} >= baudDiv)
		begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign bt.tick = tick_q;
endmodule // baud_tick_gen

// [verilog/serial_break_idle_generator.sv]
// Overview of operation
// - set then clear break bit sends one break
// - break lasts 10 or 11 bits, never doubled
// - breaks repeat while break bit stays set
// - enable clear then set queues an idle line
// - idle directly before break keeps break exact
`timescale 1ns/1ps
`include "brk_idle_defines.svh"
module serial_break_idle_generator #(
	parameter int DIV_W = 16
) (
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic resetn, // async reset, active low
	input wire logic breakSendBit, // break request level
	input wire logic transmitterEnableBit, // transmitter enable level
	input wire logic wordLengthSel, // 0: 10-bit frame, 1: 11-bit frame
	input wire logic [DIV_W-1:0] baudDiv, // clocks per bit time
	output logic txLine, // transmit pin, idle high
	output logic breakActive, // a break frame is on the line
	output logic idleActive // an idle frame is on the line
);
	baud_tick_if bt();
	baud_tick_gen #(.DIV_W(DIV_W)) u_baud (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.baudDiv(baudDiv),
		.bt(bt)
	);

	brk_idle_pkg::txState_e state_q;
	brk_idle_pkg::txState_e state_d;
	logic [3:0] bitCnt_q;
	logic [3:0] bitCnt_d;
	logic [3:0] frameLen_q;
	logic [3:0] frameLen_d;
	logic brkPend_q;
	logic brkPend_d;
	logic idlePend_q;
	logic idlePend_d;
	logic enPrev_q;
	logic brkPrev_q;
	logic txLine_d;
	logic restart;

	function automatic logic [3:0] frameLen(input logic longWord);
		frameLen = longWord ? `FRAME_BITS_LONG : `FRAME_BITS_SHORT;
	endfunction

	// bit counter restarts with each frame so no partial bit doubles it
	assign bt.restart = restart;

	always_comb
	begin
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		frameLen_d = frameLen_q;
		brkPend_d = brkPend_q;
		idlePend_d = idlePend_q;
		restart = 1'b0;
		// a rising break bit is latched so a short pulse still counts
		if (breakSendBit && !brkPrev_q)
			brkPend_d = 1'b1;
		if (transmitterEnableBit && !enPrev_q)
			idlePend_d = 1'b1;
		case (state_q)
			brk_idle_pkg::TX_OFF:
			begin
				if (transmitterEnableBit)
					state_d = brk_idle_pkg::TX_READY;
			end
			brk_idle_pkg::TX_READY:
			begin
				restart = 1'b1;
				bitCnt_d = '0;
				frameLen_d = frameLen(wordLengthSel);
				if (!transmitterEnableBit)
					state_d = brk_idle_pkg::TX_OFF;
				else if (idlePend_q)
				begin
					// idle goes out first, break follows without gap
					idlePend_d = 1'b0;
					state_d = brk_idle_pkg::TX_IDLE;
				end
				else if (brkPend_q || breakSendBit)
				begin
					brkPend_d = 1'b0;
					state_d = brk_idle_pkg::TX_BREAK;
				end
			end
			default:
			begin
				if (bt.tick)
				begin
					bitCnt_d = bitCnt_q + 4'd1;
					// frameLen bit times plus one clock for the registered tick, then back to decide
					if (bitCnt_q + 4'd1 == frameLen_q)
						state_d = brk_idle_pkg::TX_READY;
				end
			end
		endcase
		if (!resetn)
			state_d = brk_idle_pkg::TX_OFF;
	end

	always_comb
	begin
		txLine_d = `LINE_MARK;
		if (state_d == brk_idle_pkg::TX_BREAK)
			txLine_d = `LINE_SPACE;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= brk_idle_pkg::TX_OFF;
			bitCnt_q <= '0;
			frameLen_q <= `FRAME_BITS_SHORT;
			brkPend_q <= 1'b0;
			idlePend_q <= 1'b0;
			enPrev_q <= 1'b0;
			brkPrev_q <= 1'b0;
			txLine <= `LINE_MARK;
			breakActive <= 1'b0;
			idleActive <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			frameLen_q <= frameLen_d;
			brkPend_q <= brkPend_d;
			idlePend_q <= idlePend_d;
			enPrev_q <= transmitterEnableBit;
			brkPrev_q <= breakSendBit;
			txLine <= txLine_d;
			breakActive <= (state_d == brk_idle_pkg::TX_BREAK);
			idleActive <= (state_d == brk_idle_pkg::TX_IDLE);
		end
	end

	// count low cycles of a break to bound its length
	logic [31:0] lowRun;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			lowRun <= '0;
		else if (state_q == brk_idle_pkg::TX_BREAK)
			lowRun <= lowRun + 32'd1;
		else
			lowRun <= '0;
	end

	sequence s_breakStart;
		state_q == brk_idle_pkg::TX_READY
			&& state_d == brk_idle_pkg::TX_BREAK;
	endsequence

	sequence s_breakEnd;
		state_q == brk_idle_pkg::TX_BREAK
			&& state_d != brk_idle_pkg::TX_BREAK;
	endsequence

	a_break_line_low: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == brk_idle_pkg::TX_BREAK |-> txLine == `LINE_SPACE)
		else $error("line not low during break");

	// a doubled break would run past one long frame
	a_break_not_doubled: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		lowRun <= 32'({16'd0, baudDiv}) * 32'(`FRAME_BITS_LONG) + 32'd2)
		else $error("break frame too long");

	a_break_ends_high: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		s_breakEnd |=> txLine == `LINE_MARK && !breakActive)
		else $error("break frame did not end");

	a_bit_count_bound: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q == brk_idle_pkg::TX_BREAK |-> bitCnt_q < frameLen_q)
		else $error("bit count past frame length");

	a_flags_exclusive: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		!(breakActive && idleActive))
		else $error("idle and break flagged together");

	a_off_line_high: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q == brk_idle_pkg::TX_OFF
			|-> txLine == `LINE_MARK && !breakActive && !idleActive)
		else $error("line not idle while disabled");

	a_break_flag_low: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		breakActive |-> txLine == `LINE_SPACE)
		else $error("break flag without low line");

	a_break_starts_low: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		s_breakStart |=> txLine == `LINE_SPACE && breakActive)
		else $error("break start not shown on line");

	a_idle_line_high: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q == brk_idle_pkg::TX_IDLE |-> txLine == `LINE_MARK)
		else $error("idle frame not high");

	a_break_repeats: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q == brk_idle_pkg::TX_READY && transmitterEnableBit
			&& !idlePend_q && breakSendBit
			|=> state_q == brk_idle_pkg::TX_BREAK)
		else $error("held break bit did not repeat");

	a_idle_before_break: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q == brk_idle_pkg::TX_READY && transmitterEnableBit
			&& idlePend_q |=> state_q == brk_idle_pkg::TX_IDLE)
		else $error("idle not sent ahead of break");

	a_frame_len_fixed: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q == brk_idle_pkg::TX_BREAK |=> $stable(frameLen_q))
		else $error("frame length changed mid frame");
endmodule // serial_break_idle_generator

// [verif/line_receiver.sv]
`timescale 1ns/1ps
module line_receiver (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic txLine, // line from the transmitter
	output logic [15:0] lowLen, // cycles of the last low run in the frameDone cycle, else the running count one cycle late
	output logic frameDone // one cycle when a low run ends
);
	logic [15:0] cnt;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
		begin
			cnt <= '0;
			lowLen <= '0;
			frameDone <= 1'b0;
		end
		else
		begin
			// any high cycle ends the run, so a gap in a break splits it
			frameDone <= txLine && cnt != 16'h0;
			lowLen <= cnt;
			cnt <= txLine ? 16'h0 : cnt + 16'h1;
		end
endmodule // line_receiver

// [verif/test_serial_break_idle_generator.sv]
`timescale 1ns/1ps
module test_serial_break_idle_generator;
	localparam int DIV = 4;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic brk = 1'b0;
	logic en = 1'b0;
	logic wl = 1'b0;
	logic txLine, breakActive, idleActive, frameDone;
	logic [15:0] lowLen, e;
	int err_count = 0;
	int checks_done = 0;
	logic [15:0] expQ[$];
	always #10 clk_sys = ~clk_sys;
	serial_break_idle_generator #(.DIV_W(16)) i_serial_break_idle_generator (
		.clk_sys(clk_sys), .resetn(resetn), .breakSendBit(brk),
		.transmitterEnableBit(en), .wordLengthSel(wl), .baudDiv(16'h4),
		.txLine(txLine), .breakActive(breakActive), .idleActive(idleActive));
	line_receiver i_line_receiver (.clk_sys(clk_sys), .resetn(resetn),
		.txLine(txLine), .lowLen(lowLen), .frameDone(frameDone));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one cycle of slack either way for the bit tick phase
	always @(negedge clk_sys)
		if (frameDone === 1'b1)
		begin
			if (expQ.size() == 0)
				chk(lowLen, 16'h0);
			else
			begin
				e = expQ.pop_front();
				chk((lowLen + 16'h1 - e <= 16'h2) ? e : lowLen, e);
			end
		end
	task automatic send(input int m, input int n, input int k);
		wl <= m[0];
		en <= 1'b0;
		@(posedge clk_sys);
		en <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 chk(16'(idleActive), 16'h1);
		chk(16'(txLine), 16'h1);
		@(posedge clk_sys);
		brk <= 1'b1;
		repeat (k) expQ.push_back(16'((10 + m) * DIV));
		repeat (n) @(posedge clk_sys);
		brk <= 1'b0;
		for (int i = 0; i < 100 && breakActive !== 1'b1; i++)
			@(posedge clk_sys);
		#1 chk(16'(breakActive), 16'h1);
		chk(16'(txLine), 16'h0);
		chk(16'(idleActive), 16'h0);
		for (int i = 0; i < 400 && expQ.size() > 0; i++)
			@(posedge clk_sys);
		// room for a stray extra break to show up
		repeat (60) @(posedge clk_sys);
		chk(16'(expQ.size()), 16'h0);
	endtask
	initial
	begin
		void'($urandom(32'h8890));
		repeat (16) @(posedge clk_sys);
		chk(16'(txLine), 16'h1);
		resetn <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			send(m, 1 + $urandom % 3, 1);
			send(m, 100, 2);
		end
		finish_test();
	end
	initial
	begin
		#200000;
		err_count++;
		finish_test();
	end
endmodule // test_serial_break_idle_generator
